// ===== hdl/beau_core.sv
// event action unit: trigger, counter toggle, trace qualification and capture
`timescale 1ns/1ps
module beau_core (
    input  wire logic                            clk_sys,
    input  wire logic                            sys_rst,
    input  wire logic                            run_mode,
    input  wire logic                            trace_capture_enable,
    input  wire logic                            bus_cyc_stb,
    input  wire logic [beau_pkg::NUM_EVENTS-1:0] event_hit,
    input  wire logic [beau_pkg::INFO_W-1:0]     bus_info,
    input  wire logic                            cfg_we,
    input  wire logic [beau_pkg::GRP_W-1:0]      cfg_group,
    input  wire logic [beau_pkg::WORD_W-1:0]     cfg_word,
    output logic                                 trigger_out,
    output logic                                 counter_run,
    output logic                                 count_pulse,
    output logic                                 trace_we,
    output logic      [beau_pkg::TADDR_W-1:0]    trace_addr,
    output logic      [beau_pkg::INFO_W-1:0]     trace_data,
    output logic      [beau_pkg::GRP_W-1:0]      active_group,
    output logic                                 trace_on
);
    import beau_pkg::*;

    logic                  run_prev_r;
    logic                  run_entry;
    logic                  live;
    logic [WORD_W-1:0]     act_word;
    logic [NUM_EVENTS-1:0] sat;
    logic [NUM_EVENTS-1:0] trg_hits;
    logic [NUM_EVENTS-1:0] tcnt_hits;
    logic [NUM_EVENTS-1:0] ttrc_hits;
    logic [NUM_EVENTS-1:0] qual_hits;
    logic [NUM_EVENTS-1:0] count_hits;
    logic [NUM_EVENTS-1:0] jmp_hits;
    logic                  jump_hit;
    logic [GRP_W-1:0]      jump_tgt;
    logic                  group_chg;
    logic [GRP_W-1:0]      group_r;
    logic [GRP_W-1:0]      group_nxt;
    logic                  trace_on_r;
    logic                  trace_on_nxt;
    logic                  counter_run_r;
    logic                  trigger_r;
    logic                  count_pulse_r;
    logic                  trace_we_r;
    logic [TADDR_W-1:0]    trace_addr_r;
    logic [INFO_W-1:0]     trace_data_r;
    logic                  record;
    beau_trace_mode_t      trace_mode;

    // action word of the active group; read address is the next group so data lines up
    beau_act_mem u_act_mem (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wr_en   (cfg_we),
        .wr_addr (cfg_group),
        .wr_data (cfg_word),
        .rd_addr (group_nxt),
        .rd_data (act_word)
    );

    assign run_entry = run_mode & ~run_prev_r;
    // events are only recognised on a bus cycle in run mode with capture enabled
    assign live      = run_mode & trace_capture_enable & bus_cyc_stb & ~run_entry; // see R13
    assign sat       = live ? event_hit : '0;
    assign trg_hits  = sat & field_vec(act_word, ACT_TRIGGER);
    assign tcnt_hits = sat & field_vec(act_word, ACT_TOG_CTR);
    assign ttrc_hits = sat & field_vec(act_word, ACT_TOG_TRACE);
    assign qual_hits = sat & field_vec(act_word, ACT_QUAL);
    assign count_hits = sat & field_vec(act_word, ACT_COUNT);
    assign jmp_hits  = sat & field_vec(act_word, ACT_JUMP);

    // lowest numbered jumping event wins when several hit together
    always_comb begin
        jump_hit = 1'b0;
        jump_tgt = group_r;
        for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
            if (jmp_hits[i]) begin
                jump_hit = 1'b1;
                jump_tgt = act_word[i*ACT_W + ACT_TGT_LSB +: GRP_W];
            end
        end
    end

    assign group_chg = jump_hit && (jump_tgt != group_r);

    always_comb begin
        if (run_entry) begin
            group_nxt = START_GROUP;
        end else if (group_chg) begin
            group_nxt = jump_tgt;
        end else begin
            group_nxt = group_r;
        end
    end

    // toggle takes priority when a group holds both toggle and qualify actions
    always_comb begin
        if (|field_vec(act_word, ACT_TOG_TRACE)) begin
            trace_mode = TM_TOGGLE;
        end else if (|field_vec(act_word, ACT_QUAL)) begin
            trace_mode = TM_QUAL;
        end else begin
            trace_mode = TM_ALL;
        end
    end

    // each satisfied toggle inverts, so several in one cycle fold into parity
    always_comb begin
        if (run_entry || !run_mode) begin
            trace_on_nxt = 1'b0; // see R14
        end else begin
            trace_on_nxt = trace_on_r ^ (^ttrc_hits); // see R6 see R7
        end
    end

    always_comb begin
        record = 1'b0;
        case (trace_mode)
            TM_ALL:    record = live; // see R8
            TM_QUAL:   record = |qual_hits; // see R9
            TM_TOGGLE: record = live & trace_on_nxt; // see R10
            default:   record = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= run_mode;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            group_r <= START_GROUP;
        end else begin
            group_r <= group_nxt;
        end
    end

    // a new group always restarts its toggle trace off, whatever came before
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            trace_on_r <= 1'b0;
        end else if (group_chg) begin
            trace_on_r <= 1'b0; // see R11
        end else begin
            trace_on_r <= trace_on_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            counter_run_r <= 1'b0;
        end else if (run_entry) begin
            counter_run_r <= 1'b0; // see R14
        end else begin
            counter_run_r <= counter_run_r ^ (^tcnt_hits); // see R4 see R5
        end
    end

    // trigger held from one bus cycle strobe to the next, so back to back hits show no gap
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            trigger_r <= 1'b0;
        end else if (run_entry || !run_mode || !trace_capture_enable) begin
            trigger_r <= 1'b0; // see R14 see R13
        end else if (bus_cyc_stb) begin
            trigger_r <= |trg_hits; // see R1 see R3
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count_pulse_r <= 1'b0;
        end else begin
            count_pulse_r <= (|count_hits) & counter_run_r;
        end
    end

    // trace memory write port; address wraps, older records are overwritten
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            trace_we_r   <= 1'b0;
            trace_addr_r <= TADDR_RST;
            trace_data_r <= '0;
        end else begin
            trace_we_r <= record;
            if (record) begin
                trace_data_r <= bus_info; // see R12
            end
            if (trace_we_r) begin
                trace_addr_r <= trace_addr_r + 1'b1; // see R12
            end
        end
    end

    assign trigger_out  = trigger_r; // see R2
    assign counter_run  = counter_run_r;
    assign count_pulse  = count_pulse_r;
    assign trace_we     = trace_we_r;
    assign trace_addr   = trace_addr_r;
    assign trace_data   = trace_data_r;
    assign active_group = group_r;
    assign trace_on     = trace_on_r;
endmodule : beau_core

// ===== hdl/beau_pkg.sv
// package and per-group action table memory for the bus event action unit
// Operation
// R1: trigger event satisfied on a bus cycle asserts trigger for that whole cycle
// R2: trigger output is active high, low when deasserted
// R3: trigger matching on consecutive cycles stays high with no gap
// R4: each satisfied counter-toggle event flips the counter run state
// R5: any number of events may carry counter-toggle, each one inverts the state
// R6: each satisfied trace-toggle event inverts the trace recording state
// R7: any number of events may carry trace-toggle, each one inverts the state
// R8: group without qualify or toggle trace actions records every bus cycle
// R9: group with qualify action records only cycles with a qualify event; a group that also holds trace-toggle actions records by toggle instead
// R10: toggle group records nothing until first toggle, then all until next
// R11: group change takes trace condition from new group, toggle restarts off
// R12: qualified cycle writes its bus information to the next trace location
// R13: with trace capture enable off no event is recognised and nothing acts
// R14: run entry stops counter, drops trigger, applies starting group trace state
`timescale 1ns/1ps
package beau_pkg;
    localparam int           NUM_EVENTS  = 4;
    localparam int           NUM_GROUPS  = 4;
    localparam int           GRP_W       = 2;
    localparam int           ACT_W       = 8;
    localparam int           WORD_W      = NUM_EVENTS * ACT_W;
    localparam int           INFO_W      = 32;
    localparam int           TADDR_W     = 10;
    // action field positions inside each event's byte
    localparam int           ACT_TRIGGER = 0;
    localparam int           ACT_TOG_CTR = 1;
    localparam int           ACT_TOG_TRACE = 2;
    localparam int           ACT_QUAL    = 3;
    localparam int           ACT_COUNT   = 4;
    localparam int           ACT_JUMP    = 5;
    localparam int           ACT_TGT_LSB = 6;
    localparam logic [GRP_W-1:0]   START_GROUP = 2'h0;
    localparam logic [TADDR_W-1:0] TADDR_RST   = 10'h000;
    localparam logic [WORD_W-1:0]  WORD_RST    = 32'h0000_0000;

    typedef enum logic [1:0] {TM_ALL, TM_QUAL, TM_TOGGLE} beau_trace_mode_t;

    // gathers one action bit of every event into a vector
    function automatic logic [NUM_EVENTS-1:0] field_vec(input logic [WORD_W-1:0] w, input int pos);
        logic [NUM_EVENTS-1:0] v;
        v = '0;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            v[i] = w[i*ACT_W + pos];
        end
        return v;
    endfunction : field_vec
endpackage : beau_pkg

// one word per group, registered read
module beau_act_mem (
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic                         wr_en,
    input  wire logic [beau_pkg::GRP_W-1:0]   wr_addr,
    input  wire logic [beau_pkg::WORD_W-1:0]  wr_data,
    input  wire logic [beau_pkg::GRP_W-1:0]   rd_addr,
    output logic      [beau_pkg::WORD_W-1:0]  rd_data
);
    import beau_pkg::*;

    logic [WORD_W-1:0] mem_r [NUM_GROUPS];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_GROUPS; i++) begin
                mem_r[i] <= WORD_RST;
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // write-through so a word written now is seen on the next read
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= WORD_RST;
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule : beau_act_mem

// ===== bench/beau_core_assertions.sv
// port checker for the bus event action unit
`timescale 1ns/1ps
module beau_core_assertions (
    input wire logic                         clk_sys,
    input wire logic                         sys_rst,
    input wire logic                         run_mode,
    input wire logic                         trace_capture_enable,
    input wire logic                         bus_cyc_stb,
    input wire logic [beau_pkg::INFO_W-1:0]  bus_info,
    input wire logic                         trigger_out,
    input wire logic                         counter_run,
    input wire logic                         trace_we,
    input wire logic [beau_pkg::TADDR_W-1:0] trace_addr,
    input wire logic [beau_pkg::INFO_W-1:0]  trace_data,
    input wire logic [beau_pkg::GRP_W-1:0]   active_group,
    input wire logic                         trace_on
);
    import beau_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // run must be settled, since the entry clock itself clears state
    sequence s_idle;
        !bus_cyc_stb && trace_capture_enable && run_mode && $past(run_mode);
    endsequence
    sequence s_off;
        !trace_capture_enable && run_mode && $past(run_mode);
    endsequence
    sequence s_cleared;
        !counter_run && !trigger_out && !trace_on && active_group == START_GROUP;
    endsequence
    trig_hold_a: assert property (s_idle |=> $stable(trigger_out)) else $error("trigger moved");
    ctr_hold_a: assert property (s_idle |=> $stable(counter_run)) else $error("counter moved");
    trace_hold_a: assert property (s_idle |=> $stable(trace_on) && $stable(active_group))
        else $error("trace state moved");
    off_quiet_a: assert property (s_off |=> !trigger_out && !trace_we && $stable(counter_run))
        else $error("action while disabled");
    entry_clear_a: assert property ($rose(run_mode) |=> s_cleared) else $error("entry not cleared");
    we_cause_a: assert property (trace_we |-> $past(bus_cyc_stb) && $past(trace_capture_enable))
        else $error("trace write without cycle");
    data_cap_a: assert property (trace_we |-> trace_data == $past(bus_info)) else $error("trace data");
    addr_step_a: assert property (trace_we |=> trace_addr == $past(trace_addr) + 10'h001)
        else $error("trace address step");
    addr_hold_a: assert property (!trace_we |=> $stable(trace_addr)) else $error("trace address moved");
    run_drop_a: assert property (!run_mode |=> !trigger_out && !trace_on) else $error("trigger out of run");
endmodule : beau_core_assertions

bind beau_core beau_core_assertions i_chk (.clk_sys, .sys_rst, .run_mode, .trace_capture_enable, .bus_cyc_stb,
    .bus_info, .trigger_out, .counter_run, .trace_we, .trace_addr, .trace_data, .active_group, .trace_on);

// ===== bench/beau_bus_model.sv
// behavioural target bus issuing one bus cycle per request
`timescale 1ns/1ps
module beau_bus_model (
    input  wire logic                            clk_sys,
    input  wire logic                            sys_rst,
    input  wire logic                            go,
    input  wire logic [beau_pkg::NUM_EVENTS-1:0] hit,
    input  wire logic [beau_pkg::INFO_W-1:0]     info,
    output logic                                 bus_cyc_stb,
    output logic      [beau_pkg::NUM_EVENTS-1:0] event_hit,
    output logic      [beau_pkg::INFO_W-1:0]     bus_info
);
    import beau_pkg::*;
    // idle lines flip every clock so a stale value is never mistaken for a cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_cyc_stb <= 1'b0;
            event_hit   <= '0;
            bus_info    <= '0;
        end else begin
            bus_cyc_stb <= go;
            event_hit   <= go ? hit : ~event_hit;
            bus_info    <= go ? info : ~bus_info;
        end
    end
endmodule : beau_bus_model

// ===== bench/tb_top.sv
// self-checking bench for the bus event action unit
`timescale 1ns/1ps
module tb_top;
    import beau_pkg::*;
    logic                  clk_sys = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  run_mode = 1'b0;
    logic                  trace_capture_enable = 1'b1;
    logic                  go = 1'b0;
    logic [NUM_EVENTS-1:0] hit = '0;
    logic [INFO_W-1:0]     info = '0;
    logic                  cfg_we = 1'b0;
    logic [GRP_W-1:0]      cfg_group = '0;
    logic [WORD_W-1:0]     cfg_word = '0;
    logic                  stb, trg, crun, twe, ton, cpls;
    logic [NUM_EVENTS-1:0] ev;
    logic [INFO_W-1:0]     bi, tdat;
    logic [TADDR_W-1:0]    tadr;
    logic [GRP_W-1:0]      grp;
    int                    n_fail = 0;
    int                    tests_run = 0;
    int                    cyc = 0;
    always #10 clk_sys = ~clk_sys;
    beau_bus_model i_bus (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .hit(hit), .info(info),
        .bus_cyc_stb(stb), .event_hit(ev), .bus_info(bi));
    beau_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .run_mode(run_mode),
        .trace_capture_enable(trace_capture_enable), .bus_cyc_stb(stb), .event_hit(ev), .bus_info(bi),
        .cfg_we(cfg_we), .cfg_group(cfg_group), .cfg_word(cfg_word), .trigger_out(trg), .counter_run(crun),
        .count_pulse(cpls), .trace_we(twe), .trace_addr(tadr), .trace_data(tdat), .active_group(grp),
        .trace_on(ton));
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic bus(logic g, logic [3:0] h, logic [31:0] d);
        @(posedge clk_sys);
        go <= g;
        hit <= h;
        info <= d;
    endtask : bus
    // answer lands two clocks after the request: one in the bus model, one in the unit
    task automatic pulse(logic [3:0] h, logic [31:0] d);
        bus(1'b1, h, d);
        bus(1'b0, 4'h0, 32'h0);
        tick();
    endtask : pulse
    task automatic start(logic [31:0] w0, logic [31:0] w1);
        @(posedge clk_sys);
        run_mode <= 1'b0;
        cfg_we <= 1'b1;
        cfg_word <= w0;
        @(posedge clk_sys);
        cfg_word <= w1;
        cfg_group <= 2'h1;
        @(posedge clk_sys);
        cfg_we <= 1'b0;
        cfg_group <= 2'h0;
        run_mode <= 1'b1;
        repeat (3) tick();
        chk("entry state", {crun, trg, ton, grp}, 32'h0);
    endtask : start
    task automatic t_trigger();
        start(32'h0000_0001, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus(i < 3, {3'h0, i < 2}, 32'hA5A5_0000 + i);
            #1;
            if (i >= 2) begin
                chk("trigger_out", trg, i < 4);
                chk("trace we", twe, 1'b1);
                chk("trace data", tdat, 32'hA5A5_0000 + i - 2);
            end
        end
        @(posedge clk_sys);
        trace_capture_enable <= 1'b0;
        pulse(4'h1, 32'h0);
        chk("disabled", {trg, twe}, 32'h0);
        chk("trace addr", tadr, 32'h3);
        @(posedge clk_sys);
        trace_capture_enable <= 1'b1;
    endtask : t_trigger
    task automatic t_toggle();
        // event3 counts only while the counter already ran before the strobe
        logic [3:0] h [6] = '{4'hA, 4'h9, 4'h0, 4'h4, 4'h0, 4'h3};
        logic [3:0] e [6] = '{4'h4, 4'hB, 4'h3, 4'h0, 4'h0, 4'h3};
        start(32'h1004_0206, 32'h0);
        foreach (h[i]) begin
            pulse(h[i], i);
            chk("toggle state", {cpls, crun, ton, twe}, e[i]);
        end
    endtask : t_toggle
    task automatic t_group();
        // leaving group 1 while tracing must not carry trace on into the next visit
        logic [3:0] h [8] = '{4'h1, 4'h0, 4'h2, 4'h0, 4'h1, 4'h2, 4'h2, 4'h0};
        logic [3:0] e [8] = '{4'h1, 4'h0, 4'h4, 4'h4, 4'h7, 4'h1, 4'h4, 4'h4};
        start(32'h0000_6008, 32'h0000_2004);
        foreach (h[i]) begin
            pulse(h[i], i);
            chk("group state", {grp, ton, twe}, e[i]);
        end
    endtask : t_group
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_trigger();
        t_toggle();
        t_group();
        give_verdict();
    end
endmodule : tb_top
